/* verilog/adc_out_regs.svh */
`ifndef ADC_OUT_REGS_SVH
`define ADC_OUT_REGS_SVH
// ----------------------------------------
// Test mode codes
// ----------------------------------------
`define TM_OFF 4'h0
`define TM_MID 4'h1
`define TM_PFS 4'h2
`define TM_NFS 4'h3
`define TM_CHK 4'h4
`define TM_PNL 4'h5
`define TM_PNS 4'h6
`define TM_WTOG 4'h7
`define TM_USER 4'h8
`define TM_BTOG 4'h9
`define TM_SYNC 4'hA
`define TM_ONE 4'hB
`define TM_MIX 4'hC
// ----------------------------------------
// Pattern words and seeds, offset binary except W_TC_PFS, MSB aligned
// ----------------------------------------
`define W_MID 16'h8000
`define W_PFS 16'hFFFC
`define W_ZERO 16'h0000
`define W_TC_PFS 16'h7FFC
`define W_CHK 16'hAAA8
`define W_CHK2 16'h5554
`define W_SYNC16 16'h01FC
`define W_SYNC12 16'h03F0
`define W_MIX16 16'hA19C
`define W_MIX12 16'hA330
`define W_PNS_FIRST 16'hFF80
`define SEED_SHORT 23'h00_01FF
`define SEED_LONG 23'h7F_FFFF
// ----------------------------------------
// Clamp limits of the 14-bit code
// ----------------------------------------
`define CLAMP_MAX 16'h1FFF
`define CLAMP_MIN 16'hE000
// ----------------------------------------
// Link timing, in link clock cycles; frame ends as last bit slot index
// ----------------------------------------
`define SUB_LAST 3'h5
`define BCLK_PERIOD 5'h0C
`define BCLK_HALF 5'h06
`define PHASE_DEFAULT 4'h3
`define PHASE_MAX 4'hB
`define LAST_2L16 4'h7
`define LAST_2L12 4'h5
`define LAST_1L16 4'hF
`define LAST_1L12 4'hB
`endif

/* verilog/adc_out_pkg.sv */
package adc_out_pkg;
  typedef logic [15:0] word_t;
endpackage : adc_out_pkg

/* verilog/test_pattern_gen.sv */
`timescale 1ns/10ps
`default_nettype none
`include "adc_out_regs.svh"
module test_pattern_gen
  import adc_out_pkg::*;
(
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic [3:0] mode_i,
  input wire logic step_i,
  input wire logic twelve_i,
  input wire logic [15:0] user_word1_i,
  input wire logic [15:0] user_word2_i,
  output word_t word_o,
  output logic follow_fmt_o
);
  logic [3:0] mode_q;
  logic alt;
  logic [22:0] pn;
  logic [36:0] pn_next;

  // Shared state: the short sequence only uses the low nine bits
  function automatic logic [36:0] pn_run(input logic [22:0] s, input logic long_sel);
    logic [22:0] r;
    logic [13:0] w;
    r = s;
    w = 14'h0000;
    for (int i = 0; i < 14; i++) begin
      w = {w[12:0], long_sel ? r[22] : r[8]};
      r = long_sel ? {r[21:0], r[22] ^ r[17]} : {r[21:0], r[8] ^ r[4]};
    end
    return {w, r};
  endfunction : pn_run

  assign pn_next = pn_run(pn, mode_i == `TM_PNL);

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mode_q <= `TM_OFF;
      alt <= 1'b0;
      pn <= `SEED_SHORT;
    end else if (mode_i != mode_q) begin
      mode_q <= mode_i;
      alt <= 1'b0;
      pn <= (mode_i == `TM_PNL) ? `SEED_LONG : `SEED_SHORT;
    end else if (step_i) begin
      alt <= ~alt;
      pn <= pn_next[22:0];
    end
  end

  always_comb begin
    follow_fmt_o = 1'b0;
    case (mode_i)
      `TM_MID: begin word_o = `W_MID; follow_fmt_o = 1'b1; end
      `TM_PFS: begin word_o = `W_PFS; follow_fmt_o = 1'b1; end
      `TM_NFS: begin word_o = `W_ZERO; follow_fmt_o = 1'b1; end
      `TM_CHK: word_o = alt ? `W_CHK2 : `W_CHK;
      `TM_PNL, `TM_PNS: begin word_o = {pn_next[36:23], 2'b00}; follow_fmt_o = 1'b1; end
      `TM_WTOG: word_o = alt ? `W_ZERO : `W_PFS;
      `TM_USER: word_o = alt ? user_word2_i : user_word1_i;
      `TM_BTOG: word_o = `W_CHK;
      `TM_SYNC: word_o = twelve_i ? `W_SYNC12 : `W_SYNC16;
      `TM_ONE: word_o = `W_MID;
      `TM_MIX: word_o = twelve_i ? `W_MIX12 : `W_MIX16;
      default: word_o = `W_ZERO;
    endcase
  end

  pn_seed_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (mode_i != mode_q && mode_i == `TM_PNS) ##1 (mode_i == `TM_PNS) |-> word_o == `W_PNS_FIRST)
    else $error("short sequence does not start from its seed");
endmodule : test_pattern_gen
`default_nettype wire

/* verilog/bank_serializer.sv */
`timescale 1ns/10ps
`default_nettype none
`include "adc_out_regs.svh"
module bank_serializer
  import adc_out_pkg::*;
(
  input wire logic link_clk_i,
  input wire logic rst_n_i,
  input wire logic load_i,
  input wire logic [2:0] sub_i,
  input wire logic [3:0] idx_i,
  input wire logic [63:0] words_i,
  input wire logic single_i,
  input wire logic twelve_i,
  input wire logic lsb_i,
  input wire logic [3:0] phase_i,
  output logic bit_clock_o,
  output logic frame_clock_o,
  output logic [3:0] lane_a_o,
  output logic [3:0] lane_b_o
);
  logic [63:0] sh;
  logic one_lane;
  logic [3:0] ph;
  logic [4:0] half;
  logic [3:0] t;
  logic [4:0] v;
  logic [3:0] ph_age;
  logic [2:0] hi_run;

  function automatic word_t order(input word_t w, input logic lsb, input logic tw);
    word_t r;
    r = w;
    if (lsb) begin
      for (int i = 0; i < 16; i++) r[i] = w[15 - i];
      if (tw) r = {r[11:0], 4'h0};
    end
    return r;
  endfunction : order

  always_ff @(posedge link_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sh <= '0;
      one_lane <= 1'b0;
      ph <= `PHASE_DEFAULT;
      half <= 5'h04;
    end else if (load_i) begin
      for (int c = 0; c < 4; c++) sh[c*16 +: 16] <= order(words_i[c*16 +: 16], lsb_i, twelve_i);
      one_lane <= single_i;
      ph <= phase_i;
      half <= single_i ? (twelve_i ? 5'h06 : 5'h08) : (twelve_i ? 5'h03 : 5'h04);
    end else if (sub_i == `SUB_LAST) begin
      for (int c = 0; c < 4; c++)
        sh[c*16 +: 16] <= one_lane ? {sh[c*16 +: 15], 1'b0} : {sh[c*16 +: 14], 2'b00};
    end
  end

  // Position inside the bit clock period, shifted back by the phase setting
  always_comb begin
    t = (idx_i[0] ? 4'h6 : 4'h0) + {1'b0, sub_i};
    v = {1'b0, t} + `BCLK_PERIOD - {1'b0, ph};
    if (v >= `BCLK_PERIOD) v = v - `BCLK_PERIOD;
  end

  always_ff @(posedge link_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bit_clock_o <= 1'b0;
      frame_clock_o <= 1'b0;
      lane_a_o <= 4'h0;
      lane_b_o <= 4'h0;
    end else begin
      bit_clock_o <= v < `BCLK_HALF;
      frame_clock_o <= {1'b0, idx_i} < half;
      for (int c = 0; c < 4; c++) begin
        lane_a_o[c] <= sh[c*16 + 15];
        lane_b_o[c] <= one_lane ? 1'b0 : sh[c*16 + 14];
      end
    end
  end

  frame_edge_a: assert property (@(posedge link_clk_i) disable iff (!rst_n_i)
    $rose(frame_clock_o) |-> $past(idx_i) == 4'h0 && $past(sub_i) == 3'h0)
    else $error("frame clock rose away from the first bit");
  lane_hold_a: assert property (@(posedge link_clk_i) disable iff (!rst_n_i)
    $changed(lane_a_o) |-> $past(sub_i) == 3'h0)
    else $error("lane changed inside a bit");
  // A phase move at a frame start leaves one odd pulse, so pulses near a move are not judged
  always_ff @(posedge link_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ph_age <= 4'h0;
      hi_run <= 3'h0;
    end else begin
      if (load_i && phase_i != ph) begin
        ph_age <= 4'h0;
      end else if (ph_age != 4'hF) begin
        ph_age <= ph_age + 4'h1;
      end
      if (!bit_clock_o) begin
        hi_run <= 3'h0;
      end else if (hi_run != 3'h7) begin
        hi_run <= hi_run + 3'h1;
      end
    end
  end

  bitclk_width_a: assert property (@(posedge link_clk_i) disable iff (!rst_n_i)
    $fell(bit_clock_o) && ph_age >= 4'h8 |-> hi_run == 3'h6)
    else $error("bit clock high time is not one data bit");
endmodule : bank_serializer
`default_nettype wire

/* verilog/adc_serial_lvds_output.sv */
`timescale 1ns/10ps
`default_nettype none
`include "adc_out_regs.svh"
// Function
// - Twos complement after reset; offset binary when the format input is set.
// - Out-of-range samples clamp to full-scale codes in either format.
// - Default two lanes per channel, eight bits per lane per sample.
// - Single-lane sends whole word on one lane; sample rate at most 62.5 MSPS.
// - Bit clock runs at four times the sample rate by default.
// - Two banks, each with own bit clock and frame clock.
// - Frame clock rises once per sample, marking each new word.
// - Bit clock phase adjustable in 30 degree steps of its period.
// - Default bit clock edges sit mid-bit, 90 degrees of its period.
// - Twelve-bit mode shortens every word to twelve bits.
// - Sixteen-bit mode sends fourteen data bits and two zeros as the word's two LSBs.
// - MSB first by default; LSB first when selected.
// - Twelve test patterns replace data; some alternate two words.
// - Some patterns follow the format choice, others ignore it.
// - User pattern words come from four programmable byte registers.
// - Standard drive after reset; reduced swing when selected.
// - Drive and termination setting applies to all eight outputs.
// - Test mode codes 0000 off through 1100 as listed.
// - Short sequence x^9+x^5+1, all-ones seed, fourteen bits per word.
module adc_serial_lvds_output
  import adc_out_pkg::*;
(
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic link_clk_i,
  input wire logic [127:0] conv_data_i,
  input wire logic sample_valid_i,
  output logic sample_ready_o,
  input wire logic offset_binary_i,
  input wire logic twelve_bit_i,
  input wire logic lsb_first_i,
  input wire logic single_lane_i,
  input wire logic [3:0] test_mode_i,
  input wire logic [7:0] user_pattern0_i,
  input wire logic [7:0] user_pattern1_i,
  input wire logic [7:0] user_pattern2_i,
  input wire logic [7:0] user_pattern3_i,
  input wire logic [3:0] clock_phase_i,
  input wire logic reduced_swing_i,
  input wire logic [3:0] drive_ctrl_i,
  output logic swing_reduced_o,
  output logic [31:0] lane_drive_o,
  output logic bank1_bit_clock_o,
  output logic bank1_frame_clock_o,
  output logic [3:0] bank1_lane_a_o,
  output logic [3:0] bank1_lane_b_o,
  output logic bank2_bit_clock_o,
  output logic bank2_frame_clock_o,
  output logic [3:0] bank2_lane_a_o,
  output logic [3:0] bank2_lane_b_o
);
  // ----------------------------------------
  // Sample domain
  // ----------------------------------------
  logic accept;
  logic req;
  logic ack_m;
  logic ack_s;
  logic ack_l;
  logic [127:0] xfer_words;
  logic xfer_single;
  logic xfer_twelve;
  logic xfer_lsb;
  logic [3:0] xfer_phase;
  wire logic [127:0] next_words;
  logic [3:0] next_phase;
  word_t pat_word;
  logic pat_fmt;

  // A new sample is taken only once the link side has picked up the last one
  assign sample_ready_o = (req == ack_s);
  assign accept = sample_valid_i & sample_ready_o;

  test_pattern_gen u_patterns (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .mode_i(test_mode_i),
    .step_i(accept),
    .twelve_i(twelve_bit_i),
    .user_word1_i({user_pattern1_i, user_pattern0_i}),
    .user_word2_i({user_pattern3_i, user_pattern2_i}),
    .word_o(pat_word),
    .follow_fmt_o(pat_fmt)
  );

  for (genvar c = 0; c < 8; c++) begin : g_chan
    logic signed [15:0] raw;
    logic signed [15:0] clip;
    word_t w;
    always_comb begin
      raw = $signed(conv_data_i[c*16 +: 16]);
      clip = raw;
      if (raw > $signed(`CLAMP_MAX)) begin
        clip = $signed(`CLAMP_MAX);
      end else if (raw < $signed(`CLAMP_MIN)) begin
        clip = $signed(`CLAMP_MIN);
      end
      w = {clip[13:0], 2'b00};
      if (test_mode_i != `TM_OFF) begin
        w = pat_word;
        if (pat_fmt && !offset_binary_i) begin
          w[15] = ~w[15];
        end
      end else if (offset_binary_i) begin
        w[15] = ~w[15];
      end
      if (twelve_bit_i) begin
        w[3:0] = 4'h0;
      end
    end
    assign next_words[c*16 +: 16] = w;
  end

  // Out-of-range phase codes fall back to the mid-bit default
  assign next_phase = (clock_phase_i > `PHASE_MAX) ? `PHASE_DEFAULT : clock_phase_i;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      req <= 1'b0;
      xfer_words <= '0;
      xfer_single <= 1'b0;
      xfer_twelve <= 1'b0;
      xfer_lsb <= 1'b0;
      xfer_phase <= `PHASE_DEFAULT;
    end else if (accept) begin
      req <= ~req;
      xfer_words <= next_words;
      xfer_single <= single_lane_i;
      xfer_twelve <= twelve_bit_i;
      xfer_lsb <= lsb_first_i;
      xfer_phase <= next_phase;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ack_m <= 1'b0;
      ack_s <= 1'b0;
    end else begin
      ack_m <= ack_l;
      ack_s <= ack_m;
    end
  end

  // ----------------------------------------
  // Output drive settings
  // ----------------------------------------
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      swing_reduced_o <= 1'b0;
    end else begin
      swing_reduced_o <= reduced_swing_i;
    end
  end

  for (genvar l = 0; l < 8; l++) begin : g_drive
    always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        lane_drive_o[l*4 +: 4] <= 4'h0;
      end else begin
        lane_drive_o[l*4 +: 4] <= drive_ctrl_i;
      end
    end
  end

  swing_copy_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    arst_n_i |=> swing_reduced_o == $past(reduced_swing_i))
    else $error("drive mode does not follow its setting");
  drive_copy_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    arst_n_i |=> lane_drive_o == {8{$past(drive_ctrl_i)}})
    else $error("drive setting not applied to every output");

  // ----------------------------------------
  // Link domain
  // ----------------------------------------
  logic lrst_m;
  logic lrst_n;
  logic req_m;
  logic req_s;
  logic req_d;
  logic [127:0] pend_words;
  logic pend_single;
  logic pend_twelve;
  logic pend_lsb;
  logic [3:0] pend_phase;
  logic [2:0] sub;
  logic [3:0] idx;
  logic [3:0] last;
  logic [3:0] next_last;
  logic load;

  // Reset leaves the link side only after two link clock edges
  always_ff @(posedge link_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      lrst_m <= 1'b0;
      lrst_n <= 1'b0;
    end else begin
      lrst_m <= 1'b1;
      lrst_n <= lrst_m;
    end
  end

  always_ff @(posedge link_clk_i or negedge lrst_n) begin
    if (!lrst_n) begin
      req_m <= 1'b0;
      req_s <= 1'b0;
      req_d <= 1'b0;
      ack_l <= 1'b0;
    end else begin
      req_m <= req;
      req_s <= req_m;
      req_d <= req_s;
      ack_l <= req_s;
    end
  end

  // The sample side holds its words until the acknowledge returns
  always_ff @(posedge link_clk_i or negedge lrst_n) begin
    if (!lrst_n) begin
      pend_words <= '0;
      pend_single <= 1'b0;
      pend_twelve <= 1'b0;
      pend_lsb <= 1'b0;
      pend_phase <= `PHASE_DEFAULT;
    end else if (req_s != req_d) begin
      pend_words <= xfer_words;
      pend_single <= xfer_single;
      pend_twelve <= xfer_twelve;
      pend_lsb <= xfer_lsb;
      pend_phase <= xfer_phase;
    end
  end

  always_comb begin
    if (pend_single) begin
      next_last = pend_twelve ? `LAST_1L12 : `LAST_1L16;
    end else begin
      next_last = pend_twelve ? `LAST_2L12 : `LAST_2L16;
    end
  end

  // Each data bit lasts six link cycles so the phase moves in sixths of a bit
  assign load = (sub == `SUB_LAST) && (idx == last);

  always_ff @(posedge link_clk_i or negedge lrst_n) begin
    if (!lrst_n) begin
      sub <= 3'h0;
      idx <= 4'h0;
      last <= `LAST_2L16;
    end else if (sub == `SUB_LAST) begin
      sub <= 3'h0;
      if (idx == last) begin
        idx <= 4'h0;
        last <= next_last;
      end else begin
        idx <= idx + 4'h1;
      end
    end else begin
      sub <= sub + 3'h1;
    end
  end

  // Both banks run from the same counters but drive their own clocks
  bank_serializer u_bank1 (
    .link_clk_i(link_clk_i),
    .rst_n_i(lrst_n),
    .load_i(load),
    .sub_i(sub),
    .idx_i(idx),
    .words_i(pend_words[63:0]),
    .single_i(pend_single),
    .twelve_i(pend_twelve),
    .lsb_i(pend_lsb),
    .phase_i(pend_phase),
    .bit_clock_o(bank1_bit_clock_o),
    .frame_clock_o(bank1_frame_clock_o),
    .lane_a_o(bank1_lane_a_o),
    .lane_b_o(bank1_lane_b_o)
  );

  bank_serializer u_bank2 (
    .link_clk_i(link_clk_i),
    .rst_n_i(lrst_n),
    .load_i(load),
    .sub_i(sub),
    .idx_i(idx),
    .words_i(pend_words[127:64]),
    .single_i(pend_single),
    .twelve_i(pend_twelve),
    .lsb_i(pend_lsb),
    .phase_i(pend_phase),
    .bit_clock_o(bank2_bit_clock_o),
    .frame_clock_o(bank2_frame_clock_o),
    .lane_a_o(bank2_lane_a_o),
    .lane_b_o(bank2_lane_b_o)
  );

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  logic [6:0] fcyc;
  logic seen;

  always_ff @(posedge link_clk_i or negedge lrst_n) begin
    if (!lrst_n) begin
      fcyc <= 7'h00;
      seen <= 1'b0;
    end else if (load) begin
      fcyc <= 7'h00;
      seen <= 1'b1;
    end else begin
      fcyc <= fcyc + 7'h01;
    end
  end

  frame_len_a: assert property (@(posedge link_clk_i) disable iff (!lrst_n)
    load && seen |-> fcyc == ({3'h0, last} + 7'h01) * 7'h06 - 7'h01)
    else $error("frame length does not match the word mode");
  clamp_pos_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    accept && test_mode_i == `TM_OFF && !offset_binary_i && !twelve_bit_i
      && $signed(conv_data_i[15:0]) > $signed(`CLAMP_MAX) |=> xfer_words[15:0] == `W_TC_PFS)
    else $error("positive overrange not clamped");
  zero_code_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    accept && test_mode_i == `TM_OFF && conv_data_i[15:0] == 16'h0000
      |=> xfer_words[15:0] == ($past(offset_binary_i) ? `W_MID : `W_ZERO))
    else $error("zero input coded in the wrong format");
  stuff_zero_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    accept && test_mode_i == `TM_OFF |=> xfer_words[1:0] == 2'b00)
    else $error("trailing stuff bits not zero");
  mode_code_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    accept && test_mode_i == `TM_PFS && offset_binary_i && !twelve_bit_i
      |=> xfer_words[127:112] == `W_PFS)
    else $error("full scale pattern code wrong");
  xfer_hold_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    !sample_ready_o |=> $stable(xfer_words) && $stable(xfer_single))
    else $error("crossing data changed before acknowledge");
endmodule : adc_serial_lvds_output
`default_nettype wire

/* verification/lvds_rx_model.sv */
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// Receiver capturing one channel of a bank
// ----------------------------------------
module lvds_rx_model (
  input wire logic bit_clock_i,
  input wire logic frame_clock_i,
  input wire logic lane_a_i,
  input wire logic lane_b_i,
  input wire logic single_i,
  input wire logic twelve_i,
  output logic [15:0] word_o
);
  logic [15:0] sr;
  logic prev_fc;
  int cnt;

  initial begin
    sr = 16'h0000;
    prev_fc = 1'b1;
    cnt = 0;
    word_o = 16'h0000;
  end

  // Both edges capture, so a missing or shifted edge shows up as a bad word
  always @(posedge bit_clock_i or negedge bit_clock_i) begin : capture
    int nbits;
    logic [15:0] s;
    nbits = twelve_i ? 12 : 16;
    s = sr;
    if (frame_clock_i && !prev_fc) begin
      s = 16'h0000;
      cnt = 0;
    end
    if (single_i) begin
      s = {s[14:0], lane_a_i};
      cnt += 1;
    end else begin
      s = {s[13:0], lane_a_i, lane_b_i};
      cnt += 2;
    end
    if (cnt == nbits) begin
      word_o <= 16'(s << (16 - nbits));
    end
    sr = s;
    prev_fc = frame_clock_i;
  end
endmodule : lvds_rx_model
`default_nettype wire

/* verification/testbench.sv */
`timescale 1ns/10ps
`default_nettype none
module testbench
  import adc_out_pkg::*;
;
  logic clk_i, arst_n_i, link_clk, valid, ob, tw, lsb, sl, rs;
  logic [127:0] conv;
  logic [3:0] tm, phase, dc;
  logic [7:0] up0, up1, up2, up3;
  logic ready, swing, b1_bc, b1_fc, b2_bc, b2_fc;
  logic [31:0] drive;
  logic [3:0] b1_a, b1_b, b2_a, b2_b;
  word_t cap1, cap2;
  int err_count, n_compared;

  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  // The link clock stands in for the PLL output already retuned for the slow sample clock
  initial begin
    link_clk = 1'b0;
    #3.7;
    forever #7.5 link_clk = ~link_clk;
  end

  adc_serial_lvds_output i_adc_serial_lvds_output (.clk_i(clk_i), .arst_n_i(arst_n_i), .link_clk_i(link_clk),
    .conv_data_i(conv), .sample_valid_i(valid), .sample_ready_o(ready), .offset_binary_i(ob),
    .twelve_bit_i(tw), .lsb_first_i(lsb), .single_lane_i(sl), .test_mode_i(tm), .user_pattern0_i(up0),
    .user_pattern1_i(up1), .user_pattern2_i(up2), .user_pattern3_i(up3), .clock_phase_i(phase),
    .reduced_swing_i(rs), .drive_ctrl_i(dc), .swing_reduced_o(swing), .lane_drive_o(drive),
    .bank1_bit_clock_o(b1_bc), .bank1_frame_clock_o(b1_fc), .bank1_lane_a_o(b1_a), .bank1_lane_b_o(b1_b),
    .bank2_bit_clock_o(b2_bc), .bank2_frame_clock_o(b2_fc), .bank2_lane_a_o(b2_a), .bank2_lane_b_o(b2_b));
  lvds_rx_model i_rx1 (.bit_clock_i(b1_bc), .frame_clock_i(b1_fc), .lane_a_i(b1_a[0]), .lane_b_i(b1_b[0]),
    .single_i(sl), .twelve_i(tw), .word_o(cap1));
  lvds_rx_model i_rx2 (.bit_clock_i(b2_bc), .frame_clock_i(b2_fc), .lane_a_i(b2_a[3]), .lane_b_i(b2_b[3]),
    .single_i(sl), .twelve_i(tw), .word_o(cap2));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  function automatic word_t expw(input word_t v);
    word_t w, r;
    logic signed [15:0] s;
    s = v;
    if (s > 16'sh1FFF) s = 16'sh1FFF;
    else if (s < 16'shE000) s = 16'shE000;
    w = {s[13:0], 2'b00};
    if (ob) w[15] = ~w[15];
    if (tw) w[3:0] = 4'h0;
    r = w;
    if (lsb) for (int i = 0; i < 16; i++) r[i] = w[15-i];
    if (lsb && tw) r = {r[11:0], 4'h0};
    return r;
  endfunction : expw

  task automatic cfg(input logic f, input logic t, input logic l, input logic s, input logic [3:0] m,
                     input logic [3:0] p);
    @(posedge clk_i);
    ob <= f;
    tw <= t;
    lsb <= l;
    sl <= s;
    tm <= m;
    phase <= p;
    @(negedge clk_i);
  endtask : cfg

  // Ch0 and ch7 carry the sample, the rest a filler that exposes lane mixups
  task automatic send(input word_t v);
    repeat (100) begin
      @(negedge clk_i);
      if (ready === 1'b1) break;
    end
    if (ready !== 1'b1) check(ready, 1);
    @(posedge clk_i);
    conv <= {v, {6{16'h0155}}, v};
    valid <= 1'b1;
    @(posedge clk_i);
    valid <= 1'b0;
    repeat (45) @(posedge clk_i);
  endtask : send

  task automatic xfer(input word_t v, input word_t e);
    send(v);
    check(cap1, e);
    check(cap2, e);
  endtask : xfer

  task automatic measure(output int off, output int nb);
    logic pf, pb;
    int t;
    pf = 1'b1;
    pb = 1'b1;
    t = -1;
    off = -1;
    nb = 0;
    repeat (400) begin
      @(posedge link_clk);
      #1;
      if (b1_fc && !pf) begin
        if (t >= 0) break;
        t = 0;
      end
      if (t >= 0 && b1_bc && !pb) begin
        if (off < 0) off = t;
        nb++;
      end
      if (t >= 0) t++;
      pf = b1_fc;
      pb = b1_bc;
    end
  endtask : measure

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_drive;
    @(posedge clk_i);
    check(swing, 0);
    rs <= 1'b1;
    dc <= 4'h5;
    repeat (3) @(posedge clk_i);
    check(swing, 1);
    check(drive, 32'h5555_5555);
  endtask : t_drive

  task automatic t_format;
    word_t vals [4] = '{16'hF0E1, 16'h7FFF, 16'h8000, 16'h0000};
    for (int f = 0; f < 2; f++) begin
      cfg(f[0], 0, 0, 0, 4'h0, 4'h3);
      foreach (vals[k]) xfer(vals[k], expw(vals[k]));
    end
  endtask : t_format

  task automatic t_shape;
    logic [2:0] c;
    for (int i = 1; i < 8; i++) begin
      c = 3'(i);
      cfg(0, c[0], c[1], c[2], 4'h0, 4'h3);
      xfer(16'hF0E1, expw(16'hF0E1));
      if (c[2]) check(b1_b, 32'h0);
    end
  endtask : t_shape

  task automatic t_patterns;
    logic [3:0] md [9] = '{4'h1, 4'h2, 4'h3, 4'h9, 4'hA, 4'hB, 4'hC, 4'h6, 4'h5};
    word_t obw [9] = '{16'h8000, 16'hFFFC, 16'h0000, 16'hAAA8, 16'h01FC, 16'h8000, 16'hA19C, 16'hFF80,
                       16'hFFFC};
    logic fol [9] = '{1, 1, 1, 0, 0, 0, 0, 1, 1};
    for (int f = 0; f < 2; f++) begin
      for (int k = 0; k < 9; k++) begin
        cfg(f[0], 0, 0, 0, md[k], 4'h3);
        xfer(16'h0155, obw[k] ^ ((fol[k] && f == 0) ? 16'h8000 : 16'h0000));
      end
    end
  endtask : t_patterns

  task automatic t_alternate;
    @(posedge clk_i);
    up0 <= 8'h34;
    up1 <= 8'h12;
    up2 <= 8'hCD;
    up3 <= 8'hAB;
    cfg(1, 0, 0, 0, 4'h4, 4'h3);
    xfer(16'h0155, 16'hAAA8);
    xfer(16'h0155, 16'h5554);
    cfg(0, 0, 0, 0, 4'h8, 4'h3);
    xfer(16'h0155, 16'h1234);
    xfer(16'h0155, 16'hABCD);
    cfg(0, 0, 0, 0, 4'h7, 4'h3);
    xfer(16'h0155, 16'hFFFC);
    xfer(16'h0155, 16'h0000);
    cfg(0, 1, 0, 0, 4'hA, 4'h3);
    xfer(16'h0155, 16'h03F0);
    cfg(0, 1, 0, 0, 4'hC, 4'h3);
    xfer(16'h0155, 16'hA330);
    cfg(0, 0, 0, 0, 4'hD, 4'h3);
    xfer(16'h0155, 16'h0000);
  endtask : t_alternate

  task automatic t_timing;
    logic [3:0] ph [5] = '{4'h3, 4'hF, 4'h7, 4'h0, 4'hB};
    int off, nb;
    foreach (ph[k]) begin
      cfg(0, 0, 0, 0, 4'h0, ph[k]);
      send(16'h0000);
      measure(off, nb);
      check(32'(off), (ph[k] > 4'hB) ? 32'd3 : 32'(ph[k]));
      check(32'(nb), 32'd4);
    end
    cfg(0, 0, 0, 0, 4'h0, 4'h3);
  endtask : t_timing

  task automatic final_report;
    if (err_count == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : final_report

  initial begin
    repeat (6000) @(posedge clk_i);
    err_count++;
    final_report;
  end

  initial begin
    err_count = 0;
    n_compared = 0;
    arst_n_i = 1'b0;
    valid = 1'b0;
    conv = '0;
    {ob, tw, lsb, sl, rs} = 5'h00;
    tm = 4'h0;
    phase = 4'h3;
    dc = 4'h0;
    {up0, up1, up2, up3} = 32'h0000_0000;
    repeat (2) @(posedge clk_i);
    arst_n_i <= 1'b1;
    t_drive;
    t_format;
    t_shape;
    t_patterns;
    t_alternate;
    t_timing;
    final_report;
  end
endmodule : testbench
`default_nettype wire
